// ===== design/uvs_map.vh
// Constants for the ultraviolet sensor command and readout block.
`ifndef UVS_MAP_VH
`define UVS_MAP_VH
// Seven-bit bus addresses.
`define UVS_ADDR_CMD 7'h38
`define UVS_ADDR_LSB 7'h38
`define UVS_ADDR_MSB 7'h39
`define UVS_ADDR_ARA 7'h0C
// Byte returned to an alert response read: own address, low bit zero.
`define UVS_ARA_REPLY 8'h70
// Command byte field positions.
`define UVS_BIT_ALERT_EN 5
`define UVS_BIT_LEVEL 4
`define UVS_BIT_MULT_HI 3
`define UVS_BIT_MULT_LO 2
`define UVS_BIT_SHUTDOWN 0
// Command reset value: refresh 1T, reserved one set, alert off.
`define UVS_CMD_RESET 8'h06
// Alert thresholds in counts.
`define UVS_THRESH_LOW 16'h0066
`define UVS_THRESH_HIGH 16'h0091
// Base period 1T in microseconds and clock rate in MHz.
`define UVS_T1_PERIOD_US 125000
`define UVS_CLOCK_MHZ 100
// Half of 1T in clock cycles.
`define UVS_HALF_T_CYCLES (`UVS_T1_PERIOD_US * `UVS_CLOCK_MHZ / 2)
`endif

// ===== design/uvs_readout.v
// I2C slave with command register, result readout and alert for the sensor.
`timescale 1ns/100ps
`include "uvs_map.vh"

module uvs_readout #(
   parameter HALF_T_CYCLES = `UVS_HALF_T_CYCLES
) (
   // Clock and reset.
   input wire i_clock,
   input wire i_sys_rst,
   // Bus pins, open drain; the enable pulls the line low.
   input wire i_scl,
   input wire i_sda,
   output reg o_sda_out,
   output reg o_sda_oe,
   // Alert pin, open drain, low when asserted.
   output reg o_alert_out,
   output reg o_alert_oe,
   // Measurement front end on the same clock.
   input wire [15:0] i_uv_sample,
   output reg o_sample_take,
   output reg o_shutdown
);

   // Bus states.
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_AACK = 3'h2;
   localparam ST_WDATA = 3'h3;
   localparam ST_WACK = 3'h4;
   localparam ST_RDATA = 3'h5;
   localparam ST_RACK = 3'h6;
   localparam ST_WAIT = 3'h7;
   // Sources for a read byte.
   localparam SRC_LSB = 2'h0;
   localparam SRC_MSB = 2'h1;
   localparam SRC_ARA = 2'h2;
   localparam [23:0] HALF_T = HALF_T_CYCLES[23:0];

   // Two-stage synchronisers plus a third stage for edge finding.
   reg scl_s1_r, scl_s2_r, scl_prev_r;
   reg sda_s1_r, sda_s2_r, sda_prev_r;
   // Bus engine state.
   reg [2:0] state_r;
   reg [3:0] bit_cnt_r;
   reg [7:0] shift_r;
   reg [7:0] tx_r;
   reg [1:0] src_r;
   reg read_r;
   // Settings, result, alert.
   reg [7:0] cmd_r;
   reg [15:0] result_r;
   reg [7:0] lsb_hold_r;
   reg alert_r;
   // Refresh timer: half-T cycle counter and half-T unit counter.
   reg [23:0] half_cnt_r;
   reg [3:0] unit_cnt_r;

   wire scl_rise = scl_s2_r & ~scl_prev_r;
   wire scl_fall = ~scl_s2_r & scl_prev_r;
   // A data change while the clock is high marks start or stop.
   wire start_det = scl_s2_r & scl_prev_r & sda_prev_r & ~sda_s2_r;
   wire stop_det = scl_s2_r & scl_prev_r & ~sda_prev_r & sda_s2_r;
   wire [6:0] addr7 = shift_r[7:1];
   wire rw_bit = shift_r[0];
   wire alert_en = cmd_r[`UVS_BIT_ALERT_EN];
   wire shutdown = cmd_r[`UVS_BIT_SHUTDOWN];
   wire [1:0] mult = cmd_r[`UVS_BIT_MULT_HI:`UVS_BIT_MULT_LO];
   // Threshold select from the level bit.
   wire [15:0] thresh = cmd_r[`UVS_BIT_LEVEL] ? `UVS_THRESH_HIGH :
                        `UVS_THRESH_LOW;
   // Half-T units per refresh: 1, 2, 4 or 8.
   wire [3:0] units = 4'h1 << mult;
   wire half_done = (half_cnt_r == HALF_T - 24'h000001);
   // Shortening the field mid period ends it at the next half-T boundary instead of wrapping.
   wire period_done = half_done & (unit_cnt_r >= units - 4'h1);
   // Clearing by an alert response byte fully sent.
   wire ara_clear = (state_r == ST_RACK) & scl_rise & (src_r == SRC_ARA);
   // New alert event from a fresh sample above the threshold.
   wire alert_set = period_done & ~shutdown & alert_en &
                    (i_uv_sample > thresh);

   // Synchronise the bus pins; only the second and third stages feed logic.
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_prev_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_prev_r <= 1'b1;
      end else begin
         scl_s1_r <= i_scl;
         scl_s2_r <= scl_s1_r;
         scl_prev_r <= scl_s2_r;
         sda_s1_r <= i_sda;
         sda_s2_r <= sda_s1_r;
         sda_prev_r <= sda_s2_r;
      end
   end

   // Refresh timer; held cleared during shutdown so a wake restarts
   // a full period rather than sampling early.
   always @(posedge i_clock) begin
      if (i_sys_rst || shutdown) begin
         half_cnt_r <= 24'h000000;
         unit_cnt_r <= 4'h0;
      end else if (half_done) begin
         half_cnt_r <= 24'h000000;
         unit_cnt_r <= period_done ? 4'h0 : unit_cnt_r + 4'h1;
      end else begin
         half_cnt_r <= half_cnt_r + 24'h000001;
      end
   end

   // Latch a new result at each period end while measuring.
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         result_r <= 16'h0000;
         o_sample_take <= 1'b0;
      end else begin
         o_sample_take <= period_done & ~shutdown;
         if (period_done && !shutdown) begin
            result_r <= i_uv_sample;
         end
      end
   end

   // Pending alert; a new event wins over a clear in the same cycle.
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         alert_r <= 1'b0;
      end else if (alert_set) begin
         alert_r <= 1'b1;
      end else if (ara_clear) begin
         alert_r <= 1'b0;
      end
   end

   // Pin outputs; a disabled alert is never driven.
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_alert_out <= 1'b0;
         o_alert_oe <= 1'b0;
         o_sda_out <= 1'b0;
         o_shutdown <= 1'b0;
      end else begin
         o_alert_out <= 1'b0;
         o_alert_oe <= alert_r & alert_en;
         o_sda_out <= 1'b0;
         o_shutdown <= shutdown;
      end
   end

   // Bus engine: sample on the rising clock, drive on the falling clock.
   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         state_r <= ST_IDLE;
         bit_cnt_r <= 4'h0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         src_r <= SRC_LSB;
         read_r <= 1'b0;
         o_sda_oe <= 1'b0;
         cmd_r <= `UVS_CMD_RESET;
         lsb_hold_r <= 8'h00;
      end else if (start_det) begin
         // A start, repeated or not, always begins a new address.
         state_r <= ST_ADDR;
         bit_cnt_r <= 4'h0;
         o_sda_oe <= 1'b0;
      end else if (stop_det) begin
         state_r <= ST_IDLE;
         o_sda_oe <= 1'b0;
      end else begin
         case (state_r)
            ST_ADDR: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_s2_r};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall && bit_cnt_r == 4'h8) begin
                  read_r <= rw_bit;
                  if (!rw_bit && addr7 == `UVS_ADDR_CMD) begin
                     state_r <= ST_AACK;
                     o_sda_oe <= 1'b1;
                  end else if (rw_bit && addr7 == `UVS_ADDR_MSB) begin
                     src_r <= SRC_MSB;
                     state_r <= ST_AACK;
                     o_sda_oe <= 1'b1;
                  end else if (rw_bit && addr7 == `UVS_ADDR_LSB) begin
                     src_r <= SRC_LSB;
                     state_r <= ST_AACK;
                     o_sda_oe <= 1'b1;
                  end else if (rw_bit && addr7 == `UVS_ADDR_ARA &&
                               alert_r) begin
                     // Only a device with a pending alert answers.
                     src_r <= SRC_ARA;
                     state_r <= ST_AACK;
                     o_sda_oe <= 1'b1;
                  end else begin
                     state_r <= ST_WAIT;
                  end
               end
            end
            ST_AACK: begin
               if (scl_fall) begin
                  bit_cnt_r <= 4'h1;
                  if (read_r) begin
                     state_r <= ST_RDATA;
                     case (src_r)
                        SRC_MSB: begin
                           // Freeze the low byte so the pair stays whole.
                           tx_r <= result_r[15:8];
                           o_sda_oe <= ~result_r[15];
                           lsb_hold_r <= result_r[7:0];
                        end
                        SRC_ARA: begin
                           tx_r <= `UVS_ARA_REPLY;
                           o_sda_oe <= (`UVS_ARA_REPLY < 8'h80);
                        end
                        default: begin
                           tx_r <= lsb_hold_r;
                           o_sda_oe <= ~lsb_hold_r[7];
                        end
                     endcase
                  end else begin
                     state_r <= ST_WDATA;
                     bit_cnt_r <= 4'h0;
                     o_sda_oe <= 1'b0;
                  end
               end
            end
            ST_WDATA: begin
               if (scl_rise) begin
                  shift_r <= {shift_r[6:0], sda_s2_r};
                  bit_cnt_r <= bit_cnt_r + 4'h1;
               end else if (scl_fall && bit_cnt_r == 4'h8) begin
                  cmd_r <= shift_r;
                  state_r <= ST_WACK;
                  o_sda_oe <= 1'b1;
               end
            end
            ST_WACK: begin
               // One byte per write; later bytes are not acknowledged.
               if (scl_fall) begin
                  o_sda_oe <= 1'b0;
                  state_r <= ST_WAIT;
               end
            end
            ST_RDATA: begin
               if (scl_fall) begin
                  if (bit_cnt_r == 4'h8) begin
                     o_sda_oe <= 1'b0;
                     state_r <= ST_RACK;
                  end else begin
                     tx_r <= {tx_r[6:0], 1'b0};
                     o_sda_oe <= ~tx_r[6];
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end
               end
            end
            ST_RACK: begin
               // Host acknowledge bit; either way the byte is final.
               if (scl_rise) begin
                  state_r <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               o_sda_oe <= 1'b0;
            end
            default: begin
               state_r <= ST_IDLE;
               o_sda_oe <= 1'b0;
            end
         endcase
      end
   end

endmodule // uvs_readout

// ===== testbench/uvt_chk.sv
// Checker for the sensor readout block ports.
`timescale 1ns/100ps
module uvt_chk #(
   parameter HALF_T_CYCLES = 20
) (
   // Clock, reset and bus pins.
   input wire i_clock,
   input wire i_sys_rst,
   input wire i_scl,
   input wire i_sda,
   input wire o_sda_out,
   input wire o_sda_oe,
   // Alert and front end.
   input wire o_alert_out,
   input wire o_alert_oe,
   input wire [15:0] i_uv_sample,
   input wire o_sample_take,
   input wire o_shutdown
);
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);
   // Cycles since the last measurement; shutdown restarts the count.
   reg [15:0] gap_r;
   always @(posedge i_clock) begin
      if (i_sys_rst || o_sample_take || o_shutdown)
         gap_r <= 16'h0000;
      else
         gap_r <= gap_r + 16'h0001;
   end
   chk_sda_low_only: assert property (o_sda_out == 1'b0)
      else $error("Data pin driven high.");
   chk_alert_low_only: assert property (o_alert_out == 1'b0)
      else $error("Alert pin driven high.");
   chk_reset_idle: assert property ($past(i_sys_rst) |->
      !o_sda_oe && !o_alert_oe && !o_shutdown)
      else $error("Outputs not idle after reset.");
   chk_take_spacing: assert property (o_sample_take |=>
      (!o_sample_take) [*8])
      else $error("Measurements too close.");
   chk_period_bound: assert property (gap_r <= 8 * HALF_T_CYCLES + 4)
      else $error("Measurement period overran.");
   chk_sda_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
      else $error("Data changed while clock high.");
   chk_ack_hold: assert property ($rose(o_sda_oe) |->
      o_sda_oe [*8])
      else $error("Driven bit too short.");
   chk_alert_take: assert property ($rose(o_alert_oe) |->
      o_sample_take || $past(o_sample_take))
      else $error("Alert rose without measurement.");
   chk_alert_clear: assert property ($fell(o_alert_oe) |-> i_scl)
      else $error("Alert released outside response.");
   chk_shut_quiet: assert property (o_shutdown && $past(o_shutdown, 3)
      |-> !o_sample_take)
      else $error("Measured during shutdown.");
   cover property (o_sample_take);
   cover property ($rose(o_alert_oe));
   cover property ($fell(o_alert_oe));
   cover property ($rose(o_shutdown));
endmodule // uvt_chk
bind uvs_readout uvt_chk #(.HALF_T_CYCLES(HALF_T_CYCLES)) chk_i (
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
   .i_sda(i_sda), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
   .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe),
   .i_uv_sample(i_uv_sample), .o_sample_take(o_sample_take),
   .o_shutdown(o_shutdown));

// ===== testbench/uvt_host.sv
// Bus master model standing in for the host controller.
`timescale 1ns/100ps
module uvt_host (
   // Wire level of the pulled-up data line.
   input wire i_sda,
   // Clock line and data pull-down of the host.
   output reg o_scl,
   output reg o_sda_low
);
   // Clock stands high between frames.
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // Data changes mid low phase, 160 ns bit time.
   task put_bit(input b);
      begin
         o_sda_low = ~b;
         #40 o_scl = 1'b1;
         #80 o_scl = 1'b0;
         #40;
      end
   endtask
   task get_bit(output b);
      begin
         o_sda_low = 1'b0;
         #40 o_scl = 1'b1;
         #40 b = i_sda;
         #40 o_scl = 1'b0;
         #40;
      end
   endtask
   // One whole single-byte transfer; odd address reads.
   task txn(input [7:0] a, input [7:0] d, output [7:0] q,
      output [1:0] ak);
      integer i;
      reg b;
      begin
         #83 o_sda_low = 1'b1;
         #80 o_scl = 1'b0;
         #40;
         for (i = 7; i >= 0; i = i - 1)
            put_bit(a[i]);
         get_bit(b);
         ak = {~b, 1'b0};
         q = 8'h00;
         for (i = 7; i >= 0; i = i - 1) begin
            if (a[0])
               get_bit(q[i]);
            else
               put_bit(d[i]);
         end
         // Host acknowledges read data; device acknowledges command.
         if (a[0])
            put_bit(1'b0);
         else begin
            get_bit(b);
            ak[0] = ~b;
         end
         o_sda_low = 1'b1;
         #40 o_scl = 1'b1;
         #80 o_sda_low = 1'b0;
         #80;
      end
   endtask
endmodule // uvt_host

// ===== testbench/test_uvs_readout.sv
// Self-checking bench for the sensor command and readout block.
`timescale 1ns/100ps
module test_uvs_readout;
   `define UVT_CHK(g, e) begin total_checks = total_checks + 1; \
      if ((g) !== (e)) begin bad_count = bad_count + 1; \
      $display("Error at %0t: got %h exp %h", $time, g, e); end end
   // Half base period, shortened to keep the run brief.
   localparam HT = 20;
   reg clock = 1'b0;
   reg sys_rst = 1'b1;
   reg [15:0] uv_sample = 16'h0000;
   wire scl, host_low, sda_oe, sda_out, alert_oe, alert_out, take, shutdown;
   // Pull-up on the data wire.
   wire sda = ~(host_low | sda_oe);
   integer bad_count = 0, total_checks = 0, n, i, seed = 32'h807A8EB7;
   reg [7:0] q, hi;
   reg [1:0] ak;
   reg e;
   always #5 clock = ~clock;
   uvs_readout #(.HALF_T_CYCLES(HT)) uvs_readout_i (.i_clock(clock),
      .i_sys_rst(sys_rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
      .o_sda_oe(sda_oe), .o_alert_out(alert_out), .o_alert_oe(alert_oe),
      .i_uv_sample(uv_sample), .o_sample_take(take), .o_shutdown(shutdown));
   uvt_host host_i (.i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
   // Alert expected from enable, level and the sample.
   function exp_alert(input en, input lvl, input [15:0] s);
      exp_alert = en && (s > (lvl ? 16'h0091 : 16'h0066));
   endfunction
   // Measurement spacing for a refresh code.
   function integer exp_gap(input [1:0] rf);
      exp_gap = HT << rf;
   endfunction
   task stop_test;
      begin
         if (bad_count == 0 && total_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // Falling edges up to the next measurement pulse, bounded at 1000.
   task wait_take;
      begin
         n = 0;
         @(negedge clock);
         while (take !== 1'b1 && n < 999) begin
            n = n + 1;
            @(negedge clock);
         end
         n = n + 1;
      end
   endtask
   task cmd(input [7:0] c);
      begin
         host_i.txn(8'h70, c, q, ak);
         `UVT_CHK(ak, 2'b11)
      end
   endtask
   initial begin
      repeat (10) @(negedge clock);
      sys_rst = 1'b0;
      wait_take;
      wait_take;
      `UVT_CHK(n, exp_gap(2'b01))
      host_i.txn(8'h19, 8'h00, q, ak);
      `UVT_CHK(ak[1], 1'b0)
      host_i.txn(8'h71, 8'h00, q, ak);
      `UVT_CHK({ak[1], q}, 9'h100)
      cmd(8'h06);
      host_i.txn(8'h72, 8'h00, q, ak);
      `UVT_CHK(ak[1], 1'b0)
      for (i = 0; i < 4; i = i + 1) begin
         cmd({4'h0, i[1:0], 2'b10});
         wait_take;
         wait_take;
         `UVT_CHK(n, exp_gap(i[1:0]))
      end
      cmd(8'h03);
      `UVT_CHK(shutdown, 1'b1)
      wait_take;
      `UVT_CHK(n, 1000)
      cmd(8'h02);
      wait_take;
      wait_take;
      `UVT_CHK(n, exp_gap(2'b00))
      for (i = 0; i < 4; i = i + 1) begin
         @(negedge clock);
         uv_sample = (i == 0) ? 16'hFFFF : $random(seed);
         wait_take;
         wait_take;
         host_i.txn(8'h73, 8'h00, hi, ak);
         host_i.txn(8'h71, 8'h00, q, ak);
         `UVT_CHK({hi, q}, uv_sample)
      end
      // Start from a quiet sample so a stale value cannot raise the alert.
      @(negedge clock);
      uv_sample = 16'h0000;
      // Threshold and one above, both levels, alert on and off.
      for (i = 0; i < 8; i = i + 1) begin
         cmd({2'b00, ~i[2], i[0], 4'h2});
         @(negedge clock);
         uv_sample = (i[0] ? 16'h0091 : 16'h0066) + i[1];
         e = exp_alert(~i[2], i[0], uv_sample);
         wait_take;
         wait_take;
         `UVT_CHK(alert_oe, e)
         @(negedge clock);
         uv_sample = 16'h0000;
         host_i.txn(8'h19, 8'h00, q, ak);
         `UVT_CHK({ak[1], q}, {e, e ? 8'h70 : 8'hFF})
         repeat (4) @(negedge clock);
         `UVT_CHK(alert_oe, 1'b0)
      end
      stop_test;
   end
   // Cuts a hang short well past the expected run length.
   initial begin
      #500000;
      bad_count = bad_count + 1;
      stop_test;
   end
endmodule // test_uvs_readout
